// [logic/analog_supervision_pkg.sv]
// Purpose: Shared constants and types of the analog supervision registers
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes:   Byte address is four times the register index
`default_nettype none
package analog_supervision_pkg;
   // ***************
   // Bus and map
   // ***************
   localparam int ADDR_W = 8;
   localparam int IDX_W  = ADDR_W - 2;
   localparam logic [IDX_W-1:0] IDX_CTRL_FIRST  = 6'h01;
   localparam logic [IDX_W-1:0] IDX_CTRL_SECOND = 6'h02;
   localparam logic [IDX_W-1:0] IDX_STATUS      = 6'h03;
   localparam logic [IDX_W-1:0] IDX_EVENT       = 6'h06;
   localparam logic [IDX_W-1:0] IDX_EVENT_MASK  = 6'h07;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ***************
   // Fields and resets
   // ***************
   localparam int CF_HIGH_RAIL_EN = 6;
   localparam int CF_SECOND_EN    = 5;
   localparam int CF_CLK_OUT_EN   = 4;
   localparam int CF_TRIG_EN      = 3;
   localparam int CF_TRIM_LSB     = 0;
   localparam int CS_HIGH_MASK    = 6;
   localparam int CS_SECOND_MASK  = 5;
   localparam int CS_FILTER_MASK  = 4;
   localparam int CS_SEL_LSB      = 1;
   localparam int FIELD3_W        = 3;
   localparam logic [7:0] CTRL_FIRST_RESET  = 8'h74;
   localparam logic [7:0] CTRL_SECOND_RESET = 8'h60;
   localparam logic [7:0] STATUS_RESET      = 8'h00;
   localparam logic [7:0] EVENT_RESET       = 8'h00;
   localparam logic [7:0] CTRL_FIRST_WMASK  = 8'h7f;
   localparam logic [7:0] CTRL_SECOND_WMASK = 8'h7e;
   localparam logic [7:0] EVENT_WMASK       = 8'h7f;
   // ***************
   // Types
   // ***************
   typedef enum logic [2:0] {
      OUT_OFF, OUT_BUS_VOLTAGE, OUT_FILTER, OUT_HIGH_RAIL,
      OUT_SECOND_SUPPLY, OUT_ANALOG_CORE, OUT_BUS_CURRENT, OUT_TEMPERATURE
   } analog_out_sel_t;
   // Packed in status bit order 6..0
   typedef struct packed {
      logic high_rail_ok;
      logic second_supply_ok;
      logic bus_voltage_ok;
      logic filter_voltage_ok;
      logic xtal_running;
      logic thermal_warning_flag;
      logic thermal_shutdown_history;
   } monitor_t;
   localparam int MON_W = $bits(monitor_t);
   // ***************
   // Functions
   // ***************
   function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
      return addr[ADDR_W-1:2];
   endfunction
   function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] mask);
      return (old_v & ~mask) | (new_v & mask);
   endfunction
endpackage
`default_nettype wire

// [logic/analog_supervision_regs.sv]
// Purpose: Analog supervision register bank behind an AXI4-Lite slave
// Assumes: 25 MHz aclk, synchronous active-low reset
// Notes:   Monitor changes raise sticky events with a masked interrupt
//
// Contract
// RQ1 - First control register at index 0x01, reset 0x74, read/write.
// RQ2 - Bit 6 of first control enables the twenty-volt regulator.
// RQ3 - Bit 5 of first control enables the second DC-DC converter.
// RQ4 - Bit 4 of first control enables the clock output pin.
// RQ5 - Bit 3 set: trigger pin drives tx activity; clear: pin released.
// RQ6 - Bits 2 to 0 trim the twenty-volt current limit, codes 0 to 7.
// RQ7 - Second control register at index 0x02, reset 0x60, read/write.
// RQ8 - Bits 6, 5, 4 mask monitors from the save warning; 1 excludes.
// RQ9 - Bits 3 to 1 select analog output source; code 0 disables.
// RQ10 - Bits 0 and 7 of second control are reserved.
// RQ11 - Status register at index 0x03, read-only, resets to zero.
// RQ12 - Status bits 6, 5, 3 show high rail, second, filter supply good.
// RQ13 - Status bit 4 shows bus voltage above undervoltage threshold.
// RQ14 - Status bit 2 shows the crystal oscillator running.
// RQ15 - Status bit 1 shows a thermal warning.
// RQ16 - Status bit 0 shows that a thermal shutdown happened before.
// RQ17 - Reserved bits read zero and ignore writes.
// RQ18 - Status inputs are synchronised before they are read.
`default_nettype none
module analog_supervision_regs (
   input  wire logic                                    aclk,
   input  wire logic                                    aresetn,
   input  wire logic [analog_supervision_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                                    awvalid,
   output logic                                         awready,
   input  wire logic [31:0]                             wdata,
   input  wire logic [3:0]                              wstrb,
   input  wire logic                                    wvalid,
   output logic                                         wready,
   output logic                                         bvalid,
   output logic [1:0]                                   bresp,
   input  wire logic                                    bready,
   input  wire logic [analog_supervision_pkg::ADDR_W-1:0] araddr,
   input  wire logic                                    arvalid,
   output logic                                         arready,
   output logic                                         rvalid,
   output logic [31:0]                                  rdata,
   output logic [1:0]                                   rresp,
   input  wire logic                                    rready,
   input  wire analog_supervision_pkg::monitor_t        monitors_raw,
   input  wire logic                                    tx_activity,
   output logic                                         high_rail_regulator_enable,
   output logic                                         second_converter_enable,
   output logic                                         clock_out_enable,
   output logic [2:0]                                   high_rail_current_trim,
   output logic                                         trigger_pin_o,
   output logic                                         trigger_pin_oe,
   output analog_supervision_pkg::analog_out_sel_t      analog_out_select,
   output logic                                         save_warning_signal_n,
   output logic                                         irq
);
   import analog_supervision_pkg::*;

   // ***************
   // State
   // ***************
   typedef struct packed {
      logic [7:0]        ctrl_first;
      logic [7:0]        ctrl_second;
      logic [7:0]        event_status;
      logic [7:0]        event_mask;
      monitor_t          prev;
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [7:0]        w_data;
      logic              w_strb0;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic              trig_out;
      logic              save_n;
      logic              irq;
   } regs_state_t;

   regs_state_t st_reg;
   regs_state_t st_next;
   monitor_t    mon_sync;
   logic [7:0]  ev_set;
   logic        save_cond;

   // ***************
   // Monitor input
   // ***************
   // RQ18 two-stage sync
   status_sync #(
      .WIDTH (MON_W)
   ) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (monitors_raw),
      .sync_out (mon_sync)
   );

   assign ev_set = {1'b0, mon_sync ^ st_reg.prev};

   // RQ8 unmasked monitors drop the warning
   assign save_cond = (!mon_sync.high_rail_ok && !st_reg.ctrl_second[CS_HIGH_MASK])
                   || (!mon_sync.second_supply_ok && !st_reg.ctrl_second[CS_SECOND_MASK])
                   || (!mon_sync.filter_voltage_ok && !st_reg.ctrl_second[CS_FILTER_MASK])
                   || !mon_sync.bus_voltage_ok;

   // ***************
   // Next state
   // ***************
   always_comb begin
      logic read_clear;
      read_clear = 1'b0;
      st_next    = st_reg;
      st_next.prev = mon_sync;
      // Write address and data taken in either order
      if (awvalid && st_reg.awready) begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = awaddr;
      end
      if (wvalid && st_reg.wready) begin
         st_next.w_held  = 1'b1;
         st_next.w_data  = wdata[7:0];
         st_next.w_strb0 = wstrb[0];
      end
      if (st_reg.bvalid && bready) begin
         st_next.bvalid = 1'b0;
      end
      if (st_next.aw_held && st_next.w_held && !st_reg.bvalid) begin
         st_next.aw_held = 1'b0;
         st_next.w_held  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = RESP_OKAY;
         case (reg_index(st_next.aw_addr))
            // RQ1 first control write
            IDX_CTRL_FIRST: begin
               if (st_next.w_strb0) begin
                  // RQ17 reserved bit kept zero
                  st_next.ctrl_first = merge_byte(st_reg.ctrl_first, st_next.w_data,
                                                  CTRL_FIRST_WMASK);
               end
            end
            // RQ7 second control write
            IDX_CTRL_SECOND: begin
               if (st_next.w_strb0) begin
                  // RQ10 reserved bits kept zero
                  st_next.ctrl_second = merge_byte(st_reg.ctrl_second, st_next.w_data,
                                                   CTRL_SECOND_WMASK);
               end
            end
            IDX_EVENT_MASK: begin
               if (st_next.w_strb0) begin
                  st_next.event_mask = merge_byte(st_reg.event_mask, st_next.w_data,
                                                  EVENT_WMASK);
               end
            end
            // RQ11 read-only, write ignored
            IDX_STATUS, IDX_EVENT: begin
               st_next.bresp = RESP_OKAY;
            end
            default: begin
               st_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      st_next.awready = !st_next.aw_held && !st_next.bvalid;
      st_next.wready  = !st_next.w_held && !st_next.bvalid;
      // Read channel
      if (st_reg.rvalid && rready) begin
         st_next.rvalid = 1'b0;
      end
      if (arvalid && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rresp  = RESP_OKAY;
         st_next.rdata  = 32'h0000_0000;
         case (reg_index(araddr))
            IDX_CTRL_FIRST: begin
               st_next.rdata[7:0] = st_reg.ctrl_first;
            end
            IDX_CTRL_SECOND: begin
               st_next.rdata[7:0] = st_reg.ctrl_second;
            end
            // RQ12 RQ13 RQ14 RQ15 RQ16 live monitor levels
            IDX_STATUS: begin
               st_next.rdata[7:0] = {1'b0, mon_sync};
            end
            IDX_EVENT: begin
               st_next.rdata[7:0] = st_reg.event_status;
               read_clear = 1'b1;
            end
            IDX_EVENT_MASK: begin
               st_next.rdata[7:0] = st_reg.event_mask;
            end
            default: begin
               st_next.rresp = RESP_SLVERR;
            end
         endcase
      end
      st_next.arready = !st_next.rvalid;
      // New events win over the read clear
      st_next.event_status = (read_clear ? EVENT_RESET : st_reg.event_status) | ev_set;
      st_next.irq = |(st_next.event_status & st_next.event_mask);
      // RQ5 trigger follows tx activity
      st_next.trig_out = tx_activity;
      st_next.save_n   = !save_cond;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg             <= '0;
         st_reg.ctrl_first  <= CTRL_FIRST_RESET;
         st_reg.ctrl_second <= CTRL_SECOND_RESET;
         st_reg.event_mask  <= EVENT_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ***************
   // Outputs
   // ***************
   assign awready = st_reg.awready;
   assign wready  = st_reg.wready;
   assign bvalid  = st_reg.bvalid;
   assign bresp   = st_reg.bresp;
   assign arready = st_reg.arready;
   assign rvalid  = st_reg.rvalid;
   assign rdata   = st_reg.rdata;
   assign rresp   = st_reg.rresp;
   assign irq     = st_reg.irq;
   // RQ2 regulator enable
   assign high_rail_regulator_enable = st_reg.ctrl_first[CF_HIGH_RAIL_EN];
   // RQ3 converter enable
   assign second_converter_enable = st_reg.ctrl_first[CF_SECOND_EN];
   // RQ4 clock output enable
   assign clock_out_enable = st_reg.ctrl_first[CF_CLK_OUT_EN];
   // RQ6 current limit trim
   assign high_rail_current_trim = st_reg.ctrl_first[CF_TRIM_LSB +: FIELD3_W];
   // RQ5 pin released when disabled
   assign trigger_pin_oe = st_reg.ctrl_first[CF_TRIG_EN];
   assign trigger_pin_o  = st_reg.trig_out;
   // RQ9 analog output source
   assign analog_out_select = analog_out_sel_t'(st_reg.ctrl_second[CS_SEL_LSB +: FIELD3_W]);
   assign save_warning_signal_n = st_reg.save_n;

   // ***************
   // Assertions
   // ***************
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   reset_values_a: assert property (disable iff (1'b0) // RQ1
      !aresetn |=> st_reg.ctrl_first == CTRL_FIRST_RESET
                   && st_reg.ctrl_second == CTRL_SECOND_RESET && mon_sync == '0)
      else $error("reset values wrong");

   ctrl_write_a: assert property ( // RQ6
      $rose(st_reg.bvalid) && reg_index(st_reg.aw_addr) == IDX_CTRL_FIRST && st_reg.w_strb0
      |-> high_rail_current_trim == st_reg.w_data[2:0]
          && high_rail_regulator_enable == st_reg.w_data[CF_HIGH_RAIL_EN])
      else $error("first control write not applied");

   select_write_a: assert property ( // RQ9
      $rose(st_reg.bvalid) && reg_index(st_reg.aw_addr) == IDX_CTRL_SECOND && st_reg.w_strb0
      |-> analog_out_select == st_reg.w_data[3:1])
      else $error("output select not applied");

   reserved_zero_a: assert property ( // RQ17
      !st_reg.ctrl_first[7] && !st_reg.ctrl_second[7] && !st_reg.ctrl_second[0])
      else $error("reserved bit set");

   trigger_drive_a: assert property ( // RQ5
      $past(aresetn) && trigger_pin_oe |-> trigger_pin_o == $past(tx_activity))
      else $error("trigger pin not following activity");

   status_read_a: assert property ( // RQ11
      arvalid && arready && reg_index(araddr) == IDX_STATUS
      |=> rvalid && rresp == RESP_OKAY && rdata == {25'h0, $past(mon_sync)})
      else $error("status read wrong");

   sync_delay_a: assert property ( // RQ18
      $past(aresetn, 2) && $past(aresetn) && monitors_raw == $past(monitors_raw)
      && monitors_raw == $past(monitors_raw, 2) |-> mon_sync == monitors_raw)
      else $error("monitor sync latency wrong");

   save_warning_a: assert property ( // RQ8
      save_cond |=> !save_warning_signal_n)
      else $error("save warning not raised");

   event_wins_a: assert property (
      |ev_set |=> (st_reg.event_status & $past(ev_set)) == $past(ev_set))
      else $error("event lost");

   unmapped_read_a: assert property (
      arvalid && arready && reg_index(araddr) > IDX_EVENT_MASK
      |=> rvalid && rresp == RESP_SLVERR && rdata == 32'h0000_0000)
      else $error("unmapped read not refused");

   converter_enable_a: assert property ( // RQ3
      $rose(st_reg.bvalid) && reg_index(st_reg.aw_addr) == IDX_CTRL_FIRST && st_reg.w_strb0
      |-> second_converter_enable == st_reg.w_data[CF_SECOND_EN])
      else $error("converter enable not applied");

   clock_enable_a: assert property ( // RQ4
      $rose(st_reg.bvalid) && reg_index(st_reg.aw_addr) == IDX_CTRL_FIRST && st_reg.w_strb0
      |-> clock_out_enable == st_reg.w_data[CF_CLK_OUT_EN])
      else $error("clock output enable not applied");

   trigger_enable_a: assert property ( // RQ5
      $rose(st_reg.bvalid) && reg_index(st_reg.aw_addr) == IDX_CTRL_FIRST && st_reg.w_strb0
      |-> trigger_pin_oe == st_reg.w_data[CF_TRIG_EN])
      else $error("trigger pin enable not applied");

   mask_write_a: assert property ( // RQ8
      $rose(st_reg.bvalid) && reg_index(st_reg.aw_addr) == IDX_CTRL_SECOND && st_reg.w_strb0
      |-> st_reg.ctrl_second[CS_FILTER_MASK +: FIELD3_W] == st_reg.w_data[CS_FILTER_MASK +: FIELD3_W])
      else $error("monitor masks not applied");

   save_release_a: assert property ( // RQ8
      !save_cond |=> save_warning_signal_n)
      else $error("save warning raised without cause");

   status_readonly_a: assert property ( // RQ11
      $rose(st_reg.bvalid) && reg_index(st_reg.aw_addr) == IDX_STATUS
      |-> st_reg.bresp == RESP_OKAY && $stable(st_reg.ctrl_first) && $stable(st_reg.ctrl_second))
      else $error("status write not ignored");

   read_clear_a: assert property (
      arvalid && arready && reg_index(araddr) == IDX_EVENT && ev_set == EVENT_RESET
      |=> st_reg.event_status == EVENT_RESET)
      else $error("event status not cleared by read");

   slverr_seen_c: cover property (rvalid && rresp == RESP_SLVERR);
   write_seen_c: cover property ($rose(st_reg.bvalid) && st_reg.bresp == RESP_OKAY);
   status_seen_c: cover property (arvalid && arready && reg_index(araddr) == IDX_STATUS);
   irq_seen_c: cover property ($rose(irq));
endmodule // analog_supervision_regs
`default_nettype wire

// [logic/status_sync.sv]
// Purpose: Two-stage synchroniser for the monitor levels
// Assumes: Inputs may change at any time
// Notes:   First stage feeds only the second stage
`default_nettype none
module status_sync #(
   parameter int WIDTH = 7
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_t;

   sync_state_t st_reg;
   sync_state_t st_next;

   always_comb begin
      st_next        = st_reg;
      st_next.first  = async_in;
      st_next.second = st_reg.first;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.second;
endmodule // status_sync
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the analog supervision register bank
// Assumes: 25 MHz aclk, synchronous active-low reset, AXI4-Lite master in the bench
// Notes:   Each scenario is its own task; outputs are sampled 1 ns after an edge
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import analog_supervision_pkg::*;

   logic              aclk = 1'b0;
   logic              aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0]       wdata = '0;
   logic [3:0]        wstrb = 4'h1;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp;
   logic [31:0]       rdata;
   monitor_t          monitors_raw = '0;
   logic              tx_activity = 1'b0;
   logic              high_rail_regulator_enable, second_converter_enable, clock_out_enable;
   logic [2:0]        high_rail_current_trim;
   logic              trigger_pin_o, trigger_pin_oe, save_warning_signal_n, irq;
   analog_out_sel_t   analog_out_select;
   int                errors = 0;
   int                num_checks = 0;
   logic [31:0]       rd;
   logic [1:0]        rsp;

   analog_supervision_regs i_analog_supervision_regs (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bvalid(bvalid), .bresp(bresp), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready),
      .monitors_raw(monitors_raw), .tx_activity(tx_activity),
      .high_rail_regulator_enable(high_rail_regulator_enable),
      .second_converter_enable(second_converter_enable),
      .clock_out_enable(clock_out_enable), .high_rail_current_trim(high_rail_current_trim),
      .trigger_pin_o(trigger_pin_o), .trigger_pin_oe(trigger_pin_oe),
      .analog_out_select(analog_out_select),
      .save_warning_signal_n(save_warning_signal_n), .irq(irq)
   );

   initial begin
      forever #20 aclk = ~aclk;
   end

   // ***************
   // Common tasks
   // ***************
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask

   task automatic timed_out;
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
      report_and_stop();
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                            output logic [1:0] resp);
      int n;
      @(posedge aclk);
      awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      if (n == 50) timed_out();
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      if (n == 50) timed_out();
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic read_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
      axi_read(a, rd, rsp);
      check(rd, exp);
      check({30'h0, rsp}, {30'h0, exp_resp});
   endtask

   // ***************
   // Scenarios
   // ***************
   task automatic reset_values;
      check({27'h0, high_rail_regulator_enable, second_converter_enable, clock_out_enable,
             trigger_pin_oe, 1'b0}, 32'h1c);
      check({29'h0, high_rail_current_trim}, 32'h4);
      check({29'h0, analog_out_select}, 32'h0);
      read_check(8'h04, 32'h74, RESP_OKAY);
      read_check(8'h08, 32'h60, RESP_OKAY);
      read_check(8'h0c, 32'h00, RESP_OKAY);
   endtask

   task automatic first_control;
      axi_write(8'h04, 8'hff, 4'h1, rsp);
      settle(1);
      check({29'h0, high_rail_regulator_enable, second_converter_enable, clock_out_enable}, 32'h7);
      check({29'h0, high_rail_current_trim}, 32'h7);
      read_check(8'h04, 32'h7f, RESP_OKAY);
      @(posedge aclk) tx_activity <= 1'b1;
      settle(2);
      check({30'h0, trigger_pin_oe, trigger_pin_o}, 32'h3);
      axi_write(8'h04, 8'h00, 4'h1, rsp);
      settle(1);
      check({27'h0, high_rail_regulator_enable, second_converter_enable, clock_out_enable,
             trigger_pin_oe, 1'b0}, 32'h0);
      check({29'h0, high_rail_current_trim}, 32'h0);
      axi_write(8'h04, 8'h55, 4'h0, rsp);
      read_check(8'h04, 32'h00, RESP_OKAY);
      @(posedge aclk) tx_activity <= 1'b0;
   endtask

   task automatic output_select;
      for (int i = 0; i < 8; i++) begin
         axi_write(8'h08, 8'h81 | 8'(i << 1), 4'h1, rsp);
         settle(1);
         check({29'h0, analog_out_select}, 32'(i));
         read_check(8'h08, 32'(i << 1), RESP_OKAY);
      end
   endtask

   task automatic save_case(input logic [7:0] mask, input logic [6:0] mon, input logic exp);
      axi_write(8'h08, mask, 4'h1, rsp);
      @(posedge aclk) monitors_raw <= monitor_t'(mon);
      settle(5);
      check({31'h0, save_warning_signal_n}, {31'h0, exp});
   endtask

   task automatic save_masks;
      save_case(8'h60, 7'h7f, 1'b1);
      save_case(8'h60, 7'h3f, 1'b1);
      save_case(8'h00, 7'h3f, 1'b0);
      save_case(8'h20, 7'h5f, 1'b1);
      save_case(8'h00, 7'h5f, 1'b0);
      save_case(8'h10, 7'h77, 1'b1);
      save_case(8'h00, 7'h77, 1'b0);
      save_case(8'h70, 7'h6f, 1'b0);
   endtask

   task automatic status_bits;
      for (int i = 0; i < 7; i++) begin
         @(posedge aclk) monitors_raw <= monitor_t'(7'h1 << i);
         settle(3);
         read_check(8'h0c, 32'h1 << i, RESP_OKAY);
      end
      axi_write(8'h0c, 8'hff, 4'h1, rsp);
      check({30'h0, rsp}, {30'h0, RESP_OKAY});
      read_check(8'h0c, 32'h40, RESP_OKAY);
      read_check(8'h00, 32'h0, RESP_SLVERR);
      read_check(8'h40, 32'h0, RESP_SLVERR);
      axi_write(8'h14, 8'hff, 4'h1, rsp);
      check({30'h0, rsp}, {30'h0, RESP_SLVERR});
   endtask

   task automatic events_irq;
      @(posedge aclk) monitors_raw <= '0;
      settle(5);
      axi_write(8'h1c, 8'h02, 4'h1, rsp);
      axi_read(8'h18, rd, rsp);
      settle(2);
      check({31'h0, irq}, 32'h0);
      @(posedge aclk) monitors_raw <= monitor_t'(7'h01);
      settle(5);
      check({31'h0, irq}, 32'h0);
      @(posedge aclk) monitors_raw <= monitor_t'(7'h03);
      settle(5);
      check({31'h0, irq}, 32'h1);
      read_check(8'h18, 32'h03, RESP_OKAY);
      settle(2);
      check({31'h0, irq}, 32'h0);
      read_check(8'h18, 32'h00, RESP_OKAY);
      read_check(8'h1c, 32'h02, RESP_OKAY);
   endtask

   // ***************
   // Main sequence
   // ***************
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      settle(2);
      reset_values();
      first_control();
      output_select();
      save_masks();
      status_bits();
      events_irq();
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
